// [src/sep_device.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sep_regs.svh"

module sep_device
    import sep_pkg::*;
#(
    parameter int unsigned TWC_CYC = 32'(`SEP_TWC_MS * 1000000 / `SEP_CLK_NS),
    parameter int unsigned TEC_CYC = 32'(`SEP_TEC_MS * 1000000 / `SEP_CLK_NS),
    parameter int unsigned TWL_CYC = 32'(`SEP_TWL_MS * 1000000 / `SEP_CLK_NS)
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    sep_if.dev bus,
    output logic busy,
    output logic prog_enabled
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (TWC_CYC < 1 || TEC_CYC < 1 || TWL_CYC < 1) begin : g_chk
        $error("programming times must be at least one cycle");
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Edges after the start bit up to the end of the address
    function automatic logic [4:0] hdr_len(input logic x16);
        return x16 ? 5'(2 + `SEP_AW16) : 5'(2 + `SEP_AW8);
    endfunction

    function automatic logic [4:0] dat_len(input logic x16);
        return x16 ? 5'(`SEP_DW16) : 5'(`SEP_DW8);
    endfunction

    // Byte index of the high (lo=0) or low (lo=1) byte of a word (word mode) or the byte
    function automatic logic [6:0] byte_idx(input logic x16,
                                            input logic [6:0] a,
                                            input logic lo);
        return x16 ? {a[5:0], lo} : a;
    endfunction

    sep_dev_type s_r;
    sep_dev_type s_nxt;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Clock edges are found by comparing the second and third stages
    logic sel;
    logic rise;
    logic cs_rise;
    logic cs_fall;
    logic bit_in;
    logic [4:0] cnt_n;
    logic [`SEP_FRAME_W-1:0] sh_n;
    logic [1:0] opc_n;
    logic [1:0] sub_n;
    logic [6:0] addr_n;
    logic [6:0] bi;

    always_comb begin
        s_nxt = s_r;
        sel = s_r.cs_s[1];
        rise = s_r.sclk_s[1] & ~s_r.sclk_s[2];
        cs_rise = s_r.cs_s[1] & ~s_r.cs_s[2];
        cs_fall = ~s_r.cs_s[1] & s_r.cs_s[2];
        bit_in = s_r.si_s[1];
        cnt_n = s_r.cnt + 5'h01;
        sh_n = {s_r.sh[`SEP_FRAME_W-2:0], bit_in};
        opc_n = s_r.x16 ? sh_n[7:6] : sh_n[8:7];
        sub_n = s_r.x16 ? sh_n[5:4] : sh_n[6:5];
        addr_n = s_r.x16 ? {1'b0, sh_n[5:0]} : sh_n[6:0];
        bi = 7'h00;

        s_nxt.cs_s = {s_r.cs_s[1:0], bus.cs};
        s_nxt.sclk_s = {s_r.sclk_s[1:0], bus.sclk};
        s_nxt.si_s = {s_r.si_s[0], bus.serial_in};
        s_nxt.wsel_s = {s_r.wsel_s[0], bus.width_select};

        // Status window opens only on a select rise mid-cycle
        if (cs_rise && s_r.st == DS_PROG) begin
            s_nxt.stat_en = 1'b1;
            s_nxt.so = 1'b0;
        end
        if (cs_fall) begin
            s_nxt.stat_en = 1'b0;
            s_nxt.drv = 1'b0;
        end

        if (s_r.st == DS_PROG) begin
            // Self-timed, select and clock are ignored until done
            if (s_r.pcnt == 32'h0) begin
                s_nxt.st = DS_IDLE;
                s_nxt.so = 1'b1;
                s_nxt.cnt = 5'h00;
                // Applying the change at the end keeps reads coherent
                case (s_r.kind)
                    PK_ERASE: begin
                        bi = byte_idx(s_r.x16, s_r.addr, 1'b0);
                        s_nxt.mem[bi] = `SEP_ERASED;
                        bi = byte_idx(s_r.x16, s_r.addr, 1'b1);
                        if (s_r.x16) begin
                            s_nxt.mem[bi] = `SEP_ERASED;
                        end
                    end
                    PK_WRITE: begin
                        bi = byte_idx(s_r.x16, s_r.addr, 1'b0);
                        s_nxt.mem[bi] = s_r.x16 ? s_r.wdata[15:8]
                                                : s_r.wdata[7:0];
                        bi = byte_idx(s_r.x16, s_r.addr, 1'b1);
                        if (s_r.x16) begin
                            s_nxt.mem[bi] = s_r.wdata[7:0];
                        end
                    end
                    PK_ERASE_ALL: begin
                        for (int i = 0; i < `SEP_MEM_BYTES; i++) begin
                            s_nxt.mem[i] = `SEP_ERASED;
                        end
                    end
                    default: begin
                        for (int i = 0; i < `SEP_MEM_BYTES; i++) begin
                            s_nxt.mem[i] = (s_r.x16 && i[0] == 1'b0)
                                ? s_r.wdata[15:8] : s_r.wdata[7:0];
                        end
                    end
                endcase
            end else begin
                s_nxt.pcnt = s_r.pcnt - 32'h1;
            end
        end else if (!sel) begin
            // Deselect launches an armed cycle, otherwise resets
            if (s_r.st == DS_ARMED) begin
                s_nxt.st = DS_PROG;
                case (s_r.kind)
                    PK_ERASE_ALL: s_nxt.pcnt = TEC_CYC - 32'h1;
                    PK_WRITE_ALL: s_nxt.pcnt = TWL_CYC - 32'h1;
                    default: s_nxt.pcnt = TWC_CYC - 32'h1;
                endcase
            end else begin
                s_nxt.st = DS_IDLE;
                s_nxt.cnt = 5'h00;
            end
        end else if (rise) begin
            case (s_r.st)
                DS_IDLE: begin
                    if (bit_in) begin
                        s_nxt.st = DS_SHIFT;
                        s_nxt.cnt = 5'h00;
                        s_nxt.sh = '0;
                        s_nxt.x16 = s_r.wsel_s[1];
                    end
                end
                DS_SHIFT: begin
                    s_nxt.sh = sh_n;
                    s_nxt.cnt = cnt_n;
                    if (cnt_n == hdr_len(s_r.x16)) begin
                        s_nxt.opc = opc_n;
                        s_nxt.addr = addr_n;
                        case (opc_n)
                            `SEP_OPC_READ: begin
                                s_nxt.st = DS_READ;
                                s_nxt.rcnt = 5'h00;
                                s_nxt.drv = 1'b1;
                                s_nxt.so = 1'b0;
                                bi = byte_idx(s_r.x16, addr_n, 1'b0);
                                s_nxt.rd[15:8] = s_r.mem[bi];
                                bi = byte_idx(s_r.x16, addr_n, 1'b1);
                                s_nxt.rd[7:0] = s_r.x16 ? s_r.mem[bi]
                                                        : 8'h00;
                            end
                            `SEP_OPC_ERASE: begin
                                s_nxt.kind = PK_ERASE;
                                s_nxt.st = s_r.pe ? DS_ARMED : DS_DONE;
                            end
                            `SEP_OPC_WRITE: begin
                                s_nxt.kind = PK_WRITE;
                            end
                            default: begin
                                case (sub_n)
                                    `SEP_SUB_DIS: begin
                                        s_nxt.pe = 1'b0;
                                        s_nxt.st = DS_DONE;
                                    end
                                    `SEP_SUB_EN: begin
                                        s_nxt.pe = 1'b1;
                                        s_nxt.st = DS_DONE;
                                    end
                                    `SEP_SUB_ERASE_ALL: begin
                                        s_nxt.kind = PK_ERASE_ALL;
                                        s_nxt.st = s_r.pe ? DS_ARMED
                                                          : DS_DONE;
                                    end
                                    default: begin
                                        s_nxt.kind = PK_WRITE_ALL;
                                    end
                                endcase
                            end
                        endcase
                    end else if (cnt_n == hdr_len(s_r.x16)
                                 + dat_len(s_r.x16)) begin
                        s_nxt.wdata = s_r.x16 ? sh_n[15:0]
                                              : {8'h00, sh_n[7:0]};
                        s_nxt.st = s_r.pe ? DS_ARMED : DS_DONE;
                    end
                end
                DS_READ: begin
                    s_nxt.so = s_r.rd[15];
                    s_nxt.rd = {s_r.rd[14:0], 1'b0};
                    s_nxt.rcnt = s_r.rcnt + 5'h01;
                    if (s_r.rcnt + 5'h01 == dat_len(s_r.x16)) begin
                        s_nxt.st = DS_DONE;
                    end
                end
                default: begin
                    // Done or armed: clock and input are don't-care
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.st <= DS_IDLE;
            s_r.kind <= PK_ERASE;
            for (int i = 0; i < `SEP_MEM_BYTES; i++) begin
                s_r.mem[i] <= `SEP_ERASED;
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // One flop carries read bits and status, so the pin never glitches
    assign bus.so_out = s_r.so;
    assign bus.so_oe_b = ~(s_r.stat_en | s_r.drv);
    assign busy = (s_r.st == DS_PROG);
    assign prog_enabled = s_r.pe;

endmodule

`default_nettype wire

// [include/sep_regs.svh]
`ifndef SEP_REGS_SVH
`define SEP_REGS_SVH

// ----------------------------------------------------------------
// Frame encodings
// ----------------------------------------------------------------
`define SEP_OPC_SPEC 2'h0
`define SEP_OPC_WRITE 2'h1
`define SEP_OPC_READ 2'h2
`define SEP_OPC_ERASE 2'h3
`define SEP_SUB_DIS 2'h0
`define SEP_SUB_WRITE_ALL 2'h1
`define SEP_SUB_ERASE_ALL 2'h2
`define SEP_SUB_EN 2'h3
`define SEP_AW8 7
`define SEP_AW16 6
`define SEP_DW8 8
`define SEP_DW16 16
`define SEP_FRAME_W 25
`define SEP_MEM_BYTES 128
`define SEP_ERASED 8'hFF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SEP_CLK_NS 40
`define SEP_TWC_MS 10
`define SEP_TEC_MS 15
`define SEP_TWL_MS 30
`define SEP_TCSL_NS 250
`define SEP_TSV_NS 500
`define SEP_SCLK_HALF 4

`endif

// [include/sep_pkg.sv]
`default_nettype none
`include "sep_regs.svh"

package sep_pkg;

    typedef enum logic [2:0] {
        OP_READ, OP_WRITE, OP_ERASE, OP_ERASE_ALL, OP_WRITE_ALL,
        OP_PROG_EN, OP_PROG_DIS
    } sep_op_type;

    typedef enum logic [2:0] {
        DS_IDLE, DS_SHIFT, DS_READ, DS_DONE, DS_ARMED, DS_PROG
    } sep_dstate_type;

    typedef enum logic [1:0] {
        PK_ERASE, PK_WRITE, PK_ERASE_ALL, PK_WRITE_ALL
    } sep_pkind_type;

    typedef enum logic [2:0] {
        MS_IDLE, MS_LOW, MS_HIGH, MS_GAP, MS_POLL
    } sep_mstate_type;

    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] sclk_s;
        logic [1:0] si_s;
        logic [1:0] wsel_s;
        sep_dstate_type st;
        logic x16;
        logic [4:0] cnt;
        logic [`SEP_FRAME_W-1:0] sh;
        logic [1:0] opc;
        logic [6:0] addr;
        logic [15:0] wdata;
        logic [15:0] rd;
        logic [4:0] rcnt;
        logic pe;
        sep_pkind_type kind;
        logic [31:0] pcnt;
        logic stat_en;
        logic drv;
        logic so;
        logic [`SEP_MEM_BYTES-1:0][7:0] mem;
    } sep_dev_type;

    typedef struct packed {
        sep_mstate_type st;
        logic cs;
        logic sclk;
        logic si;
        logic [1:0] so_s;
        logic [4:0] ph;
        logic [4:0] e;
        logic [4:0] n;
        logic [4:0] first_rd;
        logic [`SEP_FRAME_W-1:0] frame;
        logic [15:0] rd;
        sep_op_type op;
        logic polled;
        logic rsp_valid;
        logic [15:0] rsp_data;
    } sep_mst_type;

endpackage

`default_nettype wire

// [include/sep_if.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Five-wire link between master and memory
// ----------------------------------------------------------------
interface sep_if;
    logic cs;
    logic sclk;
    logic serial_in;
    logic width_select;
    logic so_out;
    logic so_oe_b;
    logic so_pin;

    // Pull-up on the output wire: reads high while nobody drives it
    assign so_pin = so_oe_b ? 1'b1 : so_out;

    modport dev (
        input cs, sclk, serial_in, width_select,
        output so_out, so_oe_b
    );
    modport mst (
        output cs, sclk, serial_in, width_select,
        input so_pin
    );
endinterface

`default_nettype wire

// [src/sep_master.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sep_regs.svh"

module sep_master
    import sep_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    sep_if.mst bus,
    input wire logic wsel_x16,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire sep_op_type cmd_op,
    input wire logic [6:0] cmd_addr,
    input wire logic [15:0] cmd_wdata,
    output logic rsp_valid,
    output logic [15:0] rsp_data
);

    // ----------------------------------------------------------------
    // Timing constants
    // ----------------------------------------------------------------
    localparam logic [4:0] HALF_M1 = 5'(`SEP_SCLK_HALF - 1);
    // Least times round up to whole cycles
    localparam logic [4:0] GAP_M1 =
        5'((`SEP_TCSL_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS - 1);
    localparam logic [4:0] TSV_M1 =
        5'((`SEP_TSV_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS + 1);

    // Frame left-aligned at the top of the shift register
    function automatic logic [`SEP_FRAME_W-1:0] build(
        input logic x16, input sep_op_type op,
        input logic [6:0] a, input logic [15:0] d);
        logic [1:0] opc;
        logic [6:0] af;
        opc = `SEP_OPC_SPEC;
        af = a;
        case (op)
            OP_READ: opc = `SEP_OPC_READ;
            OP_WRITE: opc = `SEP_OPC_WRITE;
            OP_ERASE: opc = `SEP_OPC_ERASE;
            OP_ERASE_ALL: af = {`SEP_SUB_ERASE_ALL, 5'h00};
            OP_WRITE_ALL: af = {`SEP_SUB_WRITE_ALL, 5'h00};
            OP_PROG_EN: af = {`SEP_SUB_EN, 5'h00};
            default: af = {`SEP_SUB_DIS, 5'h00};
        endcase
        if (x16) begin
            return {1'b1, opc, (op >= OP_ERASE_ALL) ? af[6:1] : af[5:0], d};
        end
        return {1'b1, opc, af, d[7:0], 7'h00};
    endfunction

    sep_mst_type s_r;
    sep_mst_type s_nxt;
    logic has_data;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.so_s = {s_r.so_s[0], bus.so_pin};
        s_nxt.rsp_valid = 1'b0;
        has_data = (cmd_op == OP_READ) || (cmd_op == OP_WRITE)
                   || (cmd_op == OP_WRITE_ALL);
        case (s_r.st)
            MS_IDLE: begin
                if (cmd_valid) begin
                    s_nxt.frame = build(wsel_x16, cmd_op, cmd_addr,
                                        cmd_wdata);
                    // Start, opcode, address, then data if any
                    s_nxt.n = wsel_x16
                        ? 5'(3 + `SEP_AW16 + (has_data ? `SEP_DW16 : 0))
                        : 5'(3 + `SEP_AW8 + (has_data ? `SEP_DW8 : 0));
                    s_nxt.first_rd = wsel_x16 ? 5'(4 + `SEP_AW16)
                                              : 5'(4 + `SEP_AW8);
                    s_nxt.op = cmd_op;
                    s_nxt.e = 5'h00;
                    s_nxt.cs = 1'b1;
                    s_nxt.si = 1'b1;
                    s_nxt.polled = 1'b0;
                    s_nxt.ph = HALF_M1;
                    s_nxt.st = MS_LOW;
                end
            end
            MS_LOW: begin
                if (s_r.ph != 5'h00) begin
                    s_nxt.ph = s_r.ph - 5'h01;
                end else begin
                    // Sample just before the next rise, after settling
                    if (s_r.op == OP_READ && s_r.e >= s_r.first_rd) begin
                        s_nxt.rd = {s_r.rd[14:0], s_r.so_s[1]};
                    end
                    if (s_r.e == s_r.n) begin
                        s_nxt.cs = 1'b0;
                        s_nxt.ph = GAP_M1;
                        s_nxt.st = MS_GAP;
                    end else begin
                        s_nxt.sclk = 1'b1;
                        s_nxt.e = s_r.e + 5'h01;
                        s_nxt.ph = HALF_M1;
                        s_nxt.st = MS_HIGH;
                    end
                end
            end
            MS_HIGH: begin
                if (s_r.ph != 5'h00) begin
                    s_nxt.ph = s_r.ph - 5'h01;
                end else begin
                    // Input changes on the falling edge, far from rises
                    s_nxt.sclk = 1'b0;
                    s_nxt.frame = {s_r.frame[`SEP_FRAME_W-2:0], 1'b0};
                    s_nxt.si = s_r.frame[`SEP_FRAME_W-2];
                    s_nxt.ph = HALF_M1;
                    s_nxt.st = MS_LOW;
                end
            end
            MS_GAP: begin
                if (s_r.ph != 5'h00) begin
                    s_nxt.ph = s_r.ph - 5'h01;
                end else if (!s_r.polled && s_r.op != OP_READ
                             && s_r.op != OP_PROG_EN
                             && s_r.op != OP_PROG_DIS) begin
                    s_nxt.cs = 1'b1;
                    s_nxt.ph = TSV_M1;
                    s_nxt.st = MS_POLL;
                end else begin
                    s_nxt.rsp_valid = 1'b1;
                    s_nxt.rsp_data = s_r.rd;
                    s_nxt.st = MS_IDLE;
                end
            end
            MS_POLL: begin
                if (s_r.ph != 5'h00) begin
                    s_nxt.ph = s_r.ph - 5'h01;
                end else if (s_r.so_s[1]) begin
                    s_nxt.cs = 1'b0;
                    s_nxt.polled = 1'b1;
                    s_nxt.ph = GAP_M1;
                    s_nxt.st = MS_GAP;
                end
            end
            default: begin
                s_nxt.st = MS_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.st <= MS_IDLE;
            s_r.op <= OP_READ;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign bus.cs = s_r.cs;
    assign bus.sclk = s_r.sclk;
    assign bus.serial_in = s_r.si;
    assign bus.width_select = wsel_x16;
    assign cmd_ready = (s_r.st == MS_IDLE);
    assign rsp_valid = s_r.rsp_valid;
    assign rsp_data = s_r.rsp_data;

endmodule

`default_nettype wire

// [sim/sep_link_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Link checker
// ----------------------------------------------------------------
module sep_link_monitor (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic cs,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic width_select,
    input wire logic so_out,
    input wire logic so_oe_b,
    input wire logic so_pin
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // Master pacing: gap and clock widths, input and width-select stability seen by the memory
    AST_CS_GAP: assert property ($fell(cs) |-> !cs[*7])
        else $error("select low gap too short");
    AST_SCLK_HI: assert property ($rose(sclk) |-> sclk[*4])
        else $error("serial clock high too short");
    AST_SCLK_LO: assert property ($fell(sclk) |-> !sclk[*4])
        else $error("serial clock low too short");
    AST_SCLK_IDLE: assert property (!cs |-> !sclk)
        else $error("serial clock moves while deselected");
    AST_SI_HOLD: assert property (sclk && $past(sclk)
        |-> $stable(serial_in))
        else $error("serial input moved while clock high");
    AST_WSEL: assert property (cs |-> $stable(width_select))
        else $error("width select moved inside frame");
    // Memory output: only while selected, floats soon after deselect
    AST_OE_CS: assert property ($fell(so_oe_b) |-> cs && $past(cs, 2))
        else $error("output driven while deselected");
    AST_FLOAT: assert property ($fell(cs) |-> ##[1:5] so_oe_b)
        else $error("output not floated after deselect");
    AST_FLOAT_HOLD: assert property (!cs[*6] |-> so_oe_b && so_pin)
        else $error("output driven during standby");

    // Main traffic kinds
    COV_FRAME: cover property ($rose(cs) ##1 serial_in);
    COV_DRIVE_LO: cover property (!so_oe_b && !so_out);
    COV_DRIVE_HI: cover property (!so_oe_b && so_out);
endmodule

`default_nettype wire

// [sim/sep_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Bench: master user port drives the memory across the link
// ----------------------------------------------------------------
module sep_tb_top;
    import sep_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic wsel_x16 = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    logic rsp_valid;
    logic busy;
    logic prog_enabled;
    sep_op_type cmd_op = OP_READ;
    logic [6:0] cmd_addr = 7'h00;
    logic [15:0] cmd_wdata = 16'h0000;
    logic [15:0] rsp_data;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    int busy_cyc = 0;

    always #20 clk_sys = ~clk_sys;

    sep_if link_if ();
    // Short program times keep the run small
    sep_device #(.TWC_CYC(20), .TEC_CYC(30), .TWL_CYC(60)) i_sep_device (
        .clk_sys(clk_sys), .rst_b(rst_b), .bus(link_if),
        .busy(busy), .prog_enabled(prog_enabled));
    sep_master i_sep_master (
        .clk_sys(clk_sys), .rst_b(rst_b), .bus(link_if),
        .wsel_x16(wsel_x16), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    sep_link_monitor i_mon (
        .clk_sys(clk_sys), .rst_b(rst_b), .cs(link_if.cs),
        .sclk(link_if.sclk), .serial_in(link_if.serial_in),
        .width_select(link_if.width_select), .so_out(link_if.so_out),
        .so_oe_b(link_if.so_oe_b), .so_pin(link_if.so_pin));

    // Cycle count for the hang guard and busy length
    always @(posedge clk_sys) begin
        cyc++;
        if (busy === 1'b1) busy_cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // One command through the user port; bounded wait for the answer
    task automatic cmd(input sep_op_type op, input logic [6:0] a,
                       input logic [15:0] d);
        int n = 0;
        repeat (2) @(negedge clk_sys);
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        // Hold the request until a rising edge has seen ready high
        while (cmd_ready !== 1'b1 && n < 5000) begin
            @(negedge clk_sys);
            n++;
        end
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 5000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 5000) error_cnt++;
    endtask

    task automatic rd(input logic x16, input logic [6:0] a,
                      input logic [15:0] exp);
        wsel_x16 = x16;
        cmd(OP_READ, a, 16'h0000);
        check(x16 ? rsp_data : {8'h00, rsp_data[7:0]}, exp);
    endtask

    task automatic t_reset;
        check({14'h0, prog_enabled, busy}, 16'h0000);
        check({15'h0, link_if.so_pin}, 16'h0001);
    endtask

    task automatic t_locked;
        cmd(OP_WRITE, 7'h10, 16'h003C);
        rd(1'b0, 7'h10, 16'h00FF);
    endtask

    // Write at the top address, then busy length and read-back
    task automatic t_byte;
        int b0;
        cmd(OP_PROG_EN, 7'h00, 16'h0000);
        check({15'h0, prog_enabled}, 16'h0001);
        b0 = busy_cyc;
        cmd(OP_WRITE, 7'h7F, 16'h00A5);
        // Busy lasts exactly the programming time given to the device
        check(16'(busy_cyc - b0), 16'h0014);
        rd(1'b0, 7'h7F, 16'h00A5);
        cmd(OP_ERASE, 7'h7F, 16'h0000);
        rd(1'b0, 7'h7F, 16'h00FF);
    endtask

    // Word layout: high byte at the even byte address
    task automatic t_word;
        wsel_x16 = 1'b1;
        cmd(OP_WRITE, 7'h3F, 16'h1234);
        rd(1'b1, 7'h3F, 16'h1234);
        rd(1'b0, 7'h7E, 16'h0012);
        rd(1'b0, 7'h7F, 16'h0034);
    endtask

    task automatic t_all;
        cmd(OP_WRITE_ALL, 7'h00, 16'h005A);
        rd(1'b0, 7'h00, 16'h005A);
        rd(1'b0, 7'h7F, 16'h005A);
        cmd(OP_ERASE_ALL, 7'h00, 16'h0000);
        rd(1'b0, 7'h40, 16'h00FF);
    endtask

    task automatic t_disable;
        cmd(OP_PROG_DIS, 7'h00, 16'h0000);
        check({15'h0, prog_enabled}, 16'h0000);
        cmd(OP_WRITE, 7'h00, 16'h0077);
        rd(1'b0, 7'h00, 16'h00FF);
    endtask

    initial begin
        repeat (10) @(negedge clk_sys);
        rst_b = 1'b1;
        t_reset();
        t_locked();
        t_byte();
        t_word();
        t_all();
        t_disable();
        wrap_up();
    end
endmodule

`default_nettype wire
